//--- logic/acf_clkdiv.v
/*
  conversion clock divider: one-cycle enable pulse every (div+1)
  core clock cycles. assumes div is held stable by the caller while
  running; restart realigns the phase at the start of a conversion.
*/
`timescale 1ns/1ns
module acf_clkdiv #(
  parameter W = 5
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         run,
  input  wire [W-1:0] div,
  output reg          tick_ff
);

  reg [W-1:0] cnt_ff;

  // ==========================================
  // divide: period is (div + 1) core clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= {W{1'b0}};
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= {W{1'b0}};
      tick_ff <= 1'b0;
    end else if (cnt_ff == div) begin
      cnt_ff  <= {W{1'b0}};
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      tick_ff <= 1'b0;
    end
  end

endmodule // acf_clkdiv

//--- logic/acf_map.vh
/*
  register offsets, field positions, reset values and timing counts
  for the converter configuration and result formatting block.
  assumes inclusion by bare name from the design files.
*/
`ifndef ACF_MAP_VH
`define ACF_MAP_VH

// ==========================================
// register addresses on the special function register port
`define ACF_ADDR_CFG      8'hbc
`define ACF_ADDR_RES_LO   8'hbd
`define ACF_ADDR_RES_HI   8'hbe

// ==========================================
// configuration fields
`define ACF_DIV_MSB       7
`define ACF_DIV_LSB       3
`define ACF_LJST_BIT      2
`define ACF_EIGHT_BIT     1
`define ACF_GAIN_BIT      0

// ==========================================
// reset values
`define ACF_CFG_RESET     8'hf9
`define ACF_RES_RESET     8'h00

// ==========================================
// conversion timing in conversion clock periods
`define ACF_CYC_10BIT     5'h0b
`define ACF_CYC_8BIT      5'h09

`endif

//--- logic/acf_top.v
/*
  converter configuration register and result formatting for a
  10-bit successive-approximation converter reached as special
  function registers. assumes a single-cycle register port from the
  core, a start pulse from the sequencer, and an analog stage that
  presents a settled 10-bit code when the conversion ends.
*/
`timescale 1ns/1ns
`include "acf_map.vh"

// Function
// [RULE1] conversion clock is core clock over div+1
// [RULE2] software keeps divider nonzero with power controller
// [RULE3] bit 2 selects left or right justify
// [RULE4] justification ignored in 8-bit mode
// [RULE5] bit 1 selects 8-bit resolution
// [RULE6] bit 0 selects gain, resets to one
// [RULE7] right justify: high byte upper zeros
// [RULE8] left justify: high byte eight MSBs
// [RULE9] 8-bit mode: high byte holds result
// [RULE10] right justify: low byte eight LSBs
// [RULE11] left justify: low byte two LSBs high
// [RULE12] 8-bit mode: low byte reads zero
// [RULE13] 8-bit conversion two cycles shorter
// [RULE14] load results, drop busy, set done
// [RULE15] settings latched per conversion
module acf_top #(
  parameter DIV_W = 5
) (
  input  wire       REF_CLK,
  input  wire       SYS_RST,
  input  wire [7:0] SFR_ADDR,
  input  wire [7:0] SFR_WDATA,
  input  wire       SFR_WR,
  input  wire       SFR_RD,
  output reg  [7:0] SFR_RDATA,
  input  wire       CONV_START,
  input  wire [9:0] ANALOG_CODE,
  input  wire       DONE_FLAG_CLR,
  output reg        CONV_BUSY,
  output reg        CONV_DONE,
  output reg        GAIN_UNITY,
  output reg        SAR_TICK
);

  // ==========================================
  // declarations
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg  [7:0]       cfg_ff;
  reg  [7:0]       res_lo_ff;
  reg  [7:0]       res_hi_ff;
  reg              state_ff;
  reg              nxt_state;
  reg  [4:0]       cyc_ff;
  reg  [DIV_W-1:0] run_div_ff;
  reg              run_8b_ff;
  reg              run_lj_ff;
  reg  [7:0]       nxt_lo;
  reg  [7:0]       nxt_hi;
  reg  [7:0]       nxt_rdata;
  wire             tick;
  wire             finish;
  wire [4:0]       cyc_target;

  // ==========================================
  // conversion clock enable
  acf_clkdiv #(
    .W (DIV_W)
  ) u_div (
    .clk     (REF_CLK),
    .rst     (SYS_RST),
    .run     (state_ff),
    .div     (run_div_ff),
    .tick_ff (tick)
  ); // RULE1

  // shorter count for 8-bit: only the MSBs are resolved
  assign cyc_target = run_8b_ff ? `ACF_CYC_8BIT
                                : `ACF_CYC_10BIT; // RULE13
  assign finish = (state_ff == ST_CONV) && tick &&
                  (cyc_ff == cyc_target - 5'h01);

  // ==========================================
  // sequencer
  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = CONV_START ? ST_CONV : ST_IDLE;
      ST_CONV: nxt_state = finish ? ST_IDLE : ST_CONV;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff   <= ST_IDLE;
      cyc_ff     <= 5'h00;
      run_div_ff <= {DIV_W{1'b1}};
      run_8b_ff  <= 1'b0;
      run_lj_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && CONV_START) begin
        // snapshot settings so mid-conversion writes cannot skew it
        run_div_ff <= cfg_ff[`ACF_DIV_MSB:`ACF_DIV_LSB]; // RULE15
        run_8b_ff  <= cfg_ff[`ACF_EIGHT_BIT]; // RULE15
        run_lj_ff  <= cfg_ff[`ACF_LJST_BIT]; // RULE15
        cyc_ff     <= 5'h00;
      end else if (state_ff == ST_CONV && tick) begin
        cyc_ff <= cyc_ff + 5'h01;
      end
    end
  end

  // ==========================================
  // result formatting
  always @* begin
    if (run_8b_ff) begin
      nxt_hi = ANALOG_CODE[9:2]; // RULE9 RULE4
      nxt_lo = 8'h00; // RULE12
    end else if (run_lj_ff) begin
      nxt_hi = ANALOG_CODE[9:2]; // RULE8 RULE3
      nxt_lo = {ANALOG_CODE[1:0], 6'h00}; // RULE11
    end else begin
      nxt_hi = {6'h00, ANALOG_CODE[9:8]}; // RULE7 RULE3
      nxt_lo = ANALOG_CODE[7:0]; // RULE10
    end
  end

  // ==========================================
  // registers and status
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_ff     <= `ACF_CFG_RESET; // RULE6
      res_lo_ff  <= `ACF_RES_RESET;
      res_hi_ff  <= `ACF_RES_RESET;
      CONV_BUSY  <= 1'b0;
      CONV_DONE  <= 1'b0;
      GAIN_UNITY <= 1'b1;
      SAR_TICK   <= 1'b0;
    end else begin
      if (SFR_WR && SFR_ADDR == `ACF_ADDR_CFG)
        cfg_ff <= SFR_WDATA; // RULE5 RULE6
      // completion load wins over a same-cycle software write
      if (finish) begin
        res_hi_ff <= nxt_hi; // RULE14
        res_lo_ff <= nxt_lo; // RULE14
      end else begin
        if (SFR_WR && SFR_ADDR == `ACF_ADDR_RES_LO)
          res_lo_ff <= SFR_WDATA;
        if (SFR_WR && SFR_ADDR == `ACF_ADDR_RES_HI)
          res_hi_ff <= SFR_WDATA;
      end
      CONV_BUSY <= (nxt_state == ST_CONV);
      // set wins over clear
      if (finish)
        CONV_DONE <= 1'b1; // RULE14
      else if (DONE_FLAG_CLR)
        CONV_DONE <= 1'b0;
      // gain follows software only between conversions, so a running
      // conversion keeps the gain that it started with
      if (state_ff == ST_IDLE && !CONV_START &&
          SFR_WR && SFR_ADDR == `ACF_ADDR_CFG)
        GAIN_UNITY <= SFR_WDATA[`ACF_GAIN_BIT]; // RULE6
      else if (state_ff == ST_IDLE)
        GAIN_UNITY <= cfg_ff[`ACF_GAIN_BIT]; // RULE6 RULE15
      // divider runs one edge past the finish at div 0: mask that tick
      SAR_TICK   <= tick && (state_ff == ST_CONV); // RULE1
    end
  end

  // ==========================================
  // read port
  always @* begin
    case (SFR_ADDR)
      `ACF_ADDR_CFG:    nxt_rdata = cfg_ff;
      `ACF_ADDR_RES_LO: nxt_rdata = res_lo_ff;
      `ACF_ADDR_RES_HI: nxt_rdata = res_hi_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      SFR_RDATA <= 8'h00;
    else if (SFR_RD)
      SFR_RDATA <= nxt_rdata;
  end

endmodule // acf_top

//--- testbench/acf_stage.sv
/* sequencer and analog stage model.
   assumes the core clock only. */
`timescale 1ns/1ns
module acf_stage (
  input  wire       clk,
  input  wire       go,
  input  wire [9:0] val,
  input  wire       busy,
  output reg        start_ff,
  output wire [9:0] code
);
  reg [9:0] hold_ff;
  initial start_ff = 1'b0;
  always @(posedge clk) begin
    start_ff <= go & ~busy;
    if (go) hold_ff <= val;
  end
  // unsettled outside a conversion so a stray sample shows
  assign code = busy ? hold_ff : ~hold_ff;
endmodule // acf_stage

//--- testbench/acf_sva.sv
/* port checks for acf_top.
   assumes a bind from the bench top. */
`timescale 1ns/1ns
module acf_sva (
  input wire       REF_CLK,
  input wire       SYS_RST,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire       SFR_WR,
  input wire       CONV_START,
  input wire       DONE_FLAG_CLR,
  input wire       CONV_BUSY,
  input wire       CONV_DONE,
  input wire       GAIN_UNITY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ======
  // checks
  a_gain_copy: assert property (
    SFR_WR && SFR_ADDR == 8'hbc && !CONV_BUSY && !CONV_START
    |=> GAIN_UNITY == $past(SFR_WDATA[0]))
    else $error("gain");
  a_gain_hold: assert property (
    CONV_BUSY |=> $stable(GAIN_UNITY)) else $error("gain moved");
  a_start_busy: assert property (
    CONV_START && !CONV_BUSY |=> CONV_BUSY) else $error("no busy");
  a_busy_cause: assert property (
    $rose(CONV_BUSY) |-> $past(CONV_START)) else $error("busy");
  a_busy_min: assert property (
    $rose(CONV_BUSY) |-> CONV_BUSY [*8]) else $error("short");
  a_busy_max: assert property (
    $rose(CONV_BUSY) |-> ##[9:400] !CONV_BUSY) else $error("long");
  a_fall_done: assert property (
    $fell(CONV_BUSY) |-> CONV_DONE) else $error("no done");
  a_done_hold: assert property (
    CONV_DONE && !DONE_FLAG_CLR |=> CONV_DONE) else $error("lost");
  a_done_clear: assert property (
    DONE_FLAG_CLR && !CONV_BUSY |=> !CONV_DONE) else $error("clr");
endmodule // acf_sva

//--- testbench/tb_acf_top.sv
/* self-checking bench for acf_top.
   assumes acf_stage as far side, acf_sva bound. */
`timescale 1ns/1ns
module tb_acf_top;
  reg  REF_CLK, SYS_RST, SFR_WR, SFR_RD, DONE_FLAG_CLR, go, pend;
  reg  [7:0] SFR_ADDR, SFR_WDATA, cf, hi, lo;
  reg  [9:0] val;
  wire [7:0] SFR_RDATA;
  wire [9:0] ANALOG_CODE;
  wire CONV_START, CONV_BUSY, CONV_DONE, GAIN_UNITY, SAR_TICK;
  integer mismatches, compares, seed, i, k, tk, bc, d, nn;
  logic [7:0] exq[$];
  acf_top DUT (.*);
  acf_stage u_stage (.clk(REF_CLK), .go(go), .val(val),
    .busy(CONV_BUSY), .start_ff(CONV_START), .code(ANALOG_CODE));
  task chk(input string nm, input logic [7:0] s, e);
    compares = compares + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask
  // reads queue the expected byte, the monitor compares it
  task acc(input logic w, input logic [7:0] a, x);
    @(posedge REF_CLK);
    #1 SFR_ADDR = a;
    SFR_WDATA = x;
    SFR_WR = w;
    SFR_RD = !w;
    if (!w) exq.push_back(x);
    @(posedge REF_CLK);
    #1 SFR_WR = 0;
    SFR_RD = 0;
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 REF_CLK = ~REF_CLK;
  always @(negedge REF_CLK) begin
    if (pend === 1'b1) chk("rdata", SFR_RDATA, exq.pop_front());
    pend = SFR_RD;
    tk = tk + SAR_TICK;
    bc = bc + CONV_BUSY;
  end
  initial begin
    {REF_CLK, SYS_RST, SFR_WR, SFR_RD, DONE_FLAG_CLR, go, pend} = 7'h20;
    {SFR_ADDR, SFR_WDATA, val} = 26'h0;
    {mismatches, compares, tk, bc} = 0;
    seed = 32'h0639;
    repeat (2) @(posedge REF_CLK);
    #1 SYS_RST = 0;
    chk("gain_rst", GAIN_UNITY, 1);
    acc(0, 8'hbc, 8'hf9);
    acc(0, 8'hbd, 8'h00);
    acc(0, 8'hbe, 8'h00);
    acc(0, 8'hbf, 8'h00);
    // every justify and width pairing, divider kept nonzero
    for (i = 0; i < 8; i = i + 1) begin
      cf = {5'(i % 3 + 1), i[1:0], i[2]};
      d = cf[7:3];
      nn = cf[1] ? 9 : 11;
      val = 10'($random(seed));
      acc(1, 8'hbc, cf);
      chk("gain", GAIN_UNITY, cf[0]);
      {tk, bc} = 0;
      go = 1;
      @(posedge REF_CLK);
      #1 go = 0;
      acc(1, 8'hbc, cf ^ 8'h07);
      chk("gain_hold", GAIN_UNITY, cf[0]);
      for (k = 0; k < 500 && CONV_DONE !== 1'b1; k = k + 1)
        @(negedge REF_CLK);
      if (k == 500) begin
        mismatches = mismatches + 1;
        test_done;
      end
      repeat (2) @(negedge REF_CLK);
      chk("ticks", tk, nn);
      chk("gain_next", GAIN_UNITY, !cf[0]);
      chk("busy_len", bc >= (d + 1) * nn
        && bc <= (d + 1) * (nn + 1) + 1, 1);
      hi = cf[2:1] != 0 ? val[9:2] : {6'h00, val[9:8]};
      lo = cf[1] ? 8'h00 : cf[2] ? {val[1:0], 6'h00} : val[7:0];
      acc(0, 8'hbe, hi);
      acc(0, 8'hbd, lo);
      chk("done", CONV_DONE, 1);
      DONE_FLAG_CLR = 1;
      @(posedge REF_CLK);
      #1 DONE_FLAG_CLR = 0;
      chk("done_clr", CONV_DONE, 0);
    end
    repeat (2) @(negedge REF_CLK);
    test_done;
  end
endmodule // tb_acf_top
bind acf_top acf_sva u_sva (.*);
